// *** design/scp_pkg.sv ***
// Constants for the serial control port with interrupt aggregation.
// Assumes three importers: the control port module, its checker and its testbench.
package scp_pkg;

  // ----------------------------------------------------------------
  // Register addresses (7-bit command address field)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_MODE  = 7'h00;
  localparam logic [6:0] ADDR_STAT1 = 7'h12;
  localparam logic [6:0] ADDR_STAT2 = 7'h13;
  localparam logic [6:0] ADDR_STAT3 = 7'h14;
  localparam logic [6:0] ADDR_EN1   = 7'h15;
  localparam logic [6:0] ADDR_EN2   = 7'h16;
  localparam logic [6:0] ADDR_EN3   = 7'h17;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_READ_BIT   = 7;
  localparam int MODE_CHAIN_BIT = 7;
  localparam int MODE_REL_BIT   = 6;
  localparam logic [7:0] MODE_WR_MASK = 8'hc0;

  // Interrupt sources: status 1 in [7:0], status 2 in [15:8], status 3 in [18:16]
  localparam int NUM_SRC   = 19;
  localparam int STAT1_LSB = 0;
  localparam int STAT2_LSB = 8;
  localparam int STAT3_LSB = 16;
  localparam int STAT3_W   = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]         MODE_RST = 8'h00;
  localparam logic [NUM_SRC-1:0] EN_RST   = 19'h00000;
  localparam logic [2:0]         BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Byte phase within an access
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_CHAIN = 2'b00,
    PH_CMD   = 2'b01,
    PH_DATA  = 2'b10
  } scp_phase_e;

endpackage

// *** design/scp_control_port.sv ***
// Serial control port: register access over a 4-wire serial link, plus
// interrupt pending/enable aggregation driving an active-low request.
// Assumes sclk idles high, csN framing from the host, irqSrc pulses on clk.
//
// Contract
// - Access is command/address byte then data byte
// - Command MSB 1 reads, 0 writes; 7-bit address
// - Second byte is the data byte
// - Chip select fall resyncs to byte boundary
// - Read data driven out MSB first, output enabled
// - Output released at LSB fall or select rise
// - Serial input ignored during read data byte
// - Output stays released during write accesses
// - Change on falling clock, sample on rising
// - Chain mode adds leading chip-select byte
// - Chain selects up to eight devices by bit
// - Chain takes LSB, forwards byte shifted right
// - Chain forwards command and data unchanged
// - Pending bit set only when source enabled
// - Interrupt output is NOR of pending bits
// - Writing 1 clears that pending bit only
// - Three status and three enable registers
`timescale 1ns/1ns
module scp_control_port
  import scp_pkg::*;
(
  // System side
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [NUM_SRC-1:0]  irqSrc,
  output logic                     irqN,
  // Serial link
  input  wire logic                sclk,
  input  wire logic                csN,
  input  wire logic                sdi,
  output logic                     sdo,
  output logic                     sdoEn,
  output logic                     chainPassOut
);

  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  logic [2:0]         bitCnt_ff;
  logic [6:0]         rxShift_ff;
  scp_phase_e         phase_ff;
  scp_phase_e         nxt_phase;
  logic               selected_ff;
  logic               cmdRead_ff;
  logic [6:0]         cmdAddr_ff;
  logic [7:0]         txByte_ff;
  logic [7:0]         modeReg_ff;
  logic [NUM_SRC-1:0] enable_ff;
  logic [NUM_SRC-1:0] clrMask_ff;
  logic               clrTgl_ff;
  logic [NUM_SRC-1:0] statSync1_ff;
  logic [NUM_SRC-1:0] statSync2_ff;
  logic               sdo_ff;
  logic               sdoEn_ff;
  logic               passBit_ff;
  logic               passRaw_ff;

  // ----------------------------------------------------------------
  // System domain state
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] enSync1_ff;
  logic [NUM_SRC-1:0] enSync2_ff;
  logic               clrSync1_ff;
  logic               clrSync2_ff;
  logic               clrSync3_ff;
  logic [NUM_SRC-1:0] pend_ff;
  logic [NUM_SRC-1:0] nxt_pend;
  logic               irqN_ff;

  // ----------------------------------------------------------------
  // Link decode
  // ----------------------------------------------------------------
  wire       byteDone = (bitCnt_ff == BIT_LAST);
  wire [7:0] rxByte   = {rxShift_ff, sdi};
  wire       chainOn  = modeReg_ff[MODE_CHAIN_BIT];
  wire       relAtCs  = modeReg_ff[MODE_REL_BIT];
  wire       accessOn = !chainOn || selected_ff;
  wire       inChain  = (phase_ff == PH_CHAIN);
  wire       inCmd    = (phase_ff == PH_CMD);
  wire       inData   = (phase_ff == PH_DATA);

  // Write only for a selected write access; read data bytes are ignored
  wire       dataWrite = byteDone && inData && !cmdRead_ff && accessOn;
  wire       wrMode    = dataWrite && (cmdAddr_ff == ADDR_MODE);
  wire       wrEn1     = dataWrite && (cmdAddr_ff == ADDR_EN1);
  wire       wrEn2     = dataWrite && (cmdAddr_ff == ADDR_EN2);
  wire       wrEn3     = dataWrite && (cmdAddr_ff == ADDR_EN3);
  wire       wrStat1   = dataWrite && (cmdAddr_ff == ADDR_STAT1);
  wire       wrStat2   = dataWrite && (cmdAddr_ff == ADDR_STAT2);
  wire       wrStat3   = dataWrite && (cmdAddr_ff == ADDR_STAT3);
  wire       wrStat    = wrStat1 || wrStat2 || wrStat3;

  // Framing of the next access follows a mode write at once
  wire       chainNext = wrMode ? rxByte[MODE_CHAIN_BIT] : chainOn;

  // Clear mask aligned to the source vector
  wire [NUM_SRC-1:0] clrMaskNew =
    wrStat1 ? {{(NUM_SRC-8){1'b0}}, rxByte} :
    wrStat2 ? {{(NUM_SRC-16){1'b0}}, rxByte, 8'h00} :
              {rxByte[STAT3_W-1:0], 16'h0000};

  // Read selection from the incoming address
  wire [6:0] rdAddr = rxByte[6:0];
  wire [7:0] rdStat1 = statSync2_ff[STAT1_LSB +: 8];
  wire [7:0] rdStat2 = statSync2_ff[STAT2_LSB +: 8];
  wire [7:0] rdStat3 = {5'h00, statSync2_ff[STAT3_LSB +: STAT3_W]};
  wire [7:0] rdEn1   = enable_ff[STAT1_LSB +: 8];
  wire [7:0] rdEn2   = enable_ff[STAT2_LSB +: 8];
  wire [7:0] rdEn3   = {5'h00, enable_ff[STAT3_LSB +: STAT3_W]};
  wire [7:0] rdData  =
    (rdAddr == ADDR_MODE)  ? modeReg_ff :
    (rdAddr == ADDR_STAT1) ? rdStat1 :
    (rdAddr == ADDR_STAT2) ? rdStat2 :
    (rdAddr == ADDR_STAT3) ? rdStat3 :
    (rdAddr == ADDR_EN1)   ? rdEn1 :
    (rdAddr == ADDR_EN2)   ? rdEn2 :
    (rdAddr == ADDR_EN3)   ? rdEn3 : 8'h00;

  // ----------------------------------------------------------------
  // Byte phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    if (byteDone) begin
      unique case (phase_ff)
        PH_CHAIN: nxt_phase = PH_CMD;
        PH_CMD:   nxt_phase = PH_DATA;
        PH_DATA:  nxt_phase = chainNext ? PH_CHAIN : PH_CMD;
        default:  nxt_phase = PH_CMD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit counter and receive shifter, cleared while select is high
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge rst or posedge csN) begin
    if (rst || csN) begin
      bitCnt_ff <= 3'h0;
    end else begin
      bitCnt_ff <= bitCnt_ff + 3'h1;
    end
  end

  always_ff @(posedge sclk or posedge rst or posedge csN) begin
    if (rst || csN) begin
      rxShift_ff <= 7'h00;
    end else begin
      rxShift_ff <= rxByte[6:0];
    end
  end

  // Phase survives select high so bytes may be framed separately
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      phase_ff <= PH_CMD;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------
  // Chain select and command capture
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      selected_ff <= 1'b0;
    end else if (byteDone && inChain) begin
      selected_ff <= rxByte[0];
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cmdRead_ff <= 1'b0;
      cmdAddr_ff <= 7'h00;
      txByte_ff  <= 8'h00;
    end else if (byteDone && inCmd) begin
      cmdRead_ff <= rxByte[CMD_READ_BIT];
      cmdAddr_ff <= rxByte[6:0];
      txByte_ff  <= rdData;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers in the link domain
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      modeReg_ff <= MODE_RST;
    end else if (wrMode) begin
      modeReg_ff <= rxByte & MODE_WR_MASK;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      enable_ff <= EN_RST;
    end else begin
      if (wrEn1) begin
        enable_ff[STAT1_LSB +: 8] <= rxByte;
      end
      if (wrEn2) begin
        enable_ff[STAT2_LSB +: 8] <= rxByte;
      end
      if (wrEn3) begin
        enable_ff[STAT3_LSB +: STAT3_W] <= rxByte[STAT3_W-1:0];
      end
    end
  end

  // Clear request: mask held stable, toggle marks the event
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      clrMask_ff <= EN_RST;
    end else if (wrStat) begin
      clrMask_ff <= clrMaskNew;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      clrTgl_ff <= 1'b0;
    end else if (wrStat) begin
      clrTgl_ff <= !clrTgl_ff;
    end
  end

  // Pending bits brought into the link domain for reads
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      statSync1_ff <= EN_RST;
      statSync2_ff <= EN_RST;
    end else begin
      statSync1_ff <= pend_ff;
      statSync2_ff <= statSync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Serial output, launched on the falling clock edge
  // ----------------------------------------------------------------
  wire readDrive = inData && cmdRead_ff && accessOn;

  always_ff @(negedge sclk or posedge rst or posedge csN) begin
    if (rst || csN) begin
      sdoEn_ff <= 1'b0;
      sdo_ff   <= 1'b0;
    end else if (readDrive) begin
      sdoEn_ff <= 1'b1;
      sdo_ff   <= txByte_ff[BIT_LAST - bitCnt_ff];
    end else if (!relAtCs) begin
      sdoEn_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Chain pass-through: select byte delayed one bit, rest passed raw
  // ----------------------------------------------------------------
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      passRaw_ff <= 1'b1;
    end else begin
      passRaw_ff <= !inChain;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      passBit_ff <= 1'b0;
    end else begin
      passBit_ff <= (bitCnt_ff == 3'h0) ? 1'b0 : rxShift_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign sdo          = sdo_ff;
  assign sdoEn        = sdoEn_ff;
  assign chainPassOut = passRaw_ff ? sdi : passBit_ff;

  // ----------------------------------------------------------------
  // System domain: enables, clear event, pending bits
  // ----------------------------------------------------------------
  wire clrEvt = clrSync2_ff ^ clrSync3_ff;
  wire [NUM_SRC-1:0] clrBits = clrEvt ? clrMask_ff : EN_RST;

  // New events win over a clear in the same cycle
  assign nxt_pend = (pend_ff & ~clrBits) | (irqSrc & enSync2_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enSync1_ff <= EN_RST;
      enSync2_ff <= EN_RST;
    end else begin
      enSync1_ff <= enable_ff;
      enSync2_ff <= enSync1_ff;
    end
  end

  // Toggle synchroniser plus one stage for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clrSync1_ff <= 1'b0;
      clrSync2_ff <= 1'b0;
      clrSync3_ff <= 1'b0;
    end else begin
      clrSync1_ff <= clrTgl_ff;
      clrSync2_ff <= clrSync1_ff;
      clrSync3_ff <= clrSync2_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_ff <= EN_RST;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // Request follows the next pending value, so it is not a cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqN_ff <= 1'b1;
    end else begin
      irqN_ff <= ~|nxt_pend;
    end
  end

  assign irqN = irqN_ff;

endmodule

// *** testbench/scp_checker.sv ***
// Pin-level assertions for the serial control port.
// Assumes it is bound into scp_control_port.
`timescale 1ns/1ns
module scp_checker
  import scp_pkg::*;
(
  // Watched ports
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [NUM_SRC-1:0] irqSrc,
  input wire logic               irqN,
  input wire logic               sclk,
  input wire logic               csN,
  input wire logic               sdi,
  input wire logic               sdo,
  input wire logic               sdoEn,
  input wire logic               chainPassOut
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [2:0] bitCnt;
  logic [7:0] sdiHist;
  logic [3:0] idleCnt;
  logic       seenAcc;
  always_ff @(posedge sclk or posedge csN or posedge rst) begin
    if (rst || csN) begin
      bitCnt <= 3'h0;
    end else begin
      bitCnt <= bitCnt + 3'h1;
    end
  end
  always_ff @(posedge sclk) begin
    if (!csN) sdiHist <= {sdiHist[6:0], sdi};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idleCnt <= 4'hf;
      seenAcc <= 1'b0;
    end else begin
      idleCnt <= csN ? idleCnt + {3'h0, idleCnt != 4'hf} : 4'h0;
      seenAcc <= seenAcc | !csN;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_csRel; @(posedge clk) disable iff (rst) csN |-> !sdoEn; endproperty
  a_csRel: assert property (p_csRel) else $error("sdoEn high while deselected");
  property p_irqSet; @(posedge clk) disable iff (rst) $fell(irqN) |-> $past(|irqSrc); endproperty
  a_irqSet: assert property (p_irqSet) else $error("irqN fell without event");
  property p_irqQuiet; @(posedge clk) disable iff (rst) !seenAcc |-> irqN; endproperty
  a_irqQuiet: assert property (p_irqQuiet) else $error("irqN low with no enable");
  property p_irqClr; @(posedge clk) disable iff (rst) $rose(irqN) |-> idleCnt < 4'h8; endproperty
  a_irqClr: assert property (p_irqClr) else $error("irqN rose without write");
  property p_enStart;
    @(posedge sclk) disable iff (rst || csN) $rose(sdoEn) |-> bitCnt == 3'h0 && sdiHist[7];
  endproperty
  a_enStart: assert property (p_enStart) else $error("sdoEn start misplaced");
  property p_enHold; @(posedge sclk) disable iff (rst || csN) $rose(sdoEn) |-> sdoEn [*8]; endproperty
  a_enHold: assert property (p_enHold) else $error("sdoEn not held 8 bits");
  property p_enEnd; @(posedge sclk) disable iff (rst || csN) $fell(sdoEn) |-> bitCnt == 3'h0; endproperty
  a_enEnd: assert property (p_enEnd) else $error("sdoEn dropped mid byte");
  property p_wrQuiet;
    @(posedge sclk) disable iff (rst || csN) bitCnt == 3'h0 && !sdiHist[7] |-> !sdoEn;
  endproperty
  a_wrQuiet: assert property (p_wrQuiet) else $error("sdoEn high on write");
endmodule
bind scp_control_port scp_checker u_chk (.clk(clk), .rst(rst), .irqSrc(irqSrc), .irqN(irqN),
  .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn), .chainPassOut(chainPassOut));

// *** testbench/scp_host.sv ***
// Behavioural host master for the serial link.
// Assumes a 64 ns bit period and separate data lines.
`timescale 1ns/1ns
module scp_host (
  // Serial link
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdoEn,
  input  wire logic chainPassOut
);
  logic [7:0] rx;
  logic [7:0] en;
  logic [7:0] pass;
  logic       tail;
  event       done;
  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    sdi  = 1'b0;
  end
  // ------------------------------------------------------------
  // Byte transfer, optional select rise after it
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input int nb, input logic hold);
    csN = 1'b0;
    #16;
    for (int i = 7; i > 7 - nb; i--) begin
      sclk = 1'b0;
      sdi = tx[i];
      #32;
      sclk = 1'b1;
      rx[i] = sdoEn ? sdo : ~sdo;
      en[i] = sdoEn;
      pass[i] = chainPassOut;
      #32;
    end
    tail = 1'b0;
    if (!hold) begin
      sclk = 1'b0;
      #16;
      tail = sdoEn;
      csN = 1'b1;
      sdi = ~sdi;
      #16;
      sclk = 1'b1;
      #32;
    end
    if (nb == 8) ->done;
  endtask
endmodule

// *** testbench/scp_control_port_tb.sv ***
// Self-checking bench for the serial control port.
// Assumes scp_host as link master and scp_checker bound in.
`timescale 1ns/1ns
module scp_control_port_tb
  import scp_pkg::*;
;
  logic               clk;
  logic               rst;
  logic [NUM_SRC-1:0] irqSrc;
  wire                irqN, sclk, csN, sdi, sdo, sdoEn, chainPassOut;
  int                 fails = 0;
  int                 checked = 0;
  logic [23:0]        pend, ena, clr;
  logic               rel, hold, chainOn, sel;
  logic [25:0]        expQ[$];
  logic [7:0]         d;

  scp_control_port u_dut (.clk(clk), .rst(rst), .irqSrc(irqSrc), .irqN(irqN), .sclk(sclk),
    .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn), .chainPassOut(chainPassOut));
  scp_host u_host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
    .chainPassOut(chainPassOut));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Check, drive and monitor tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] ex);
    checked++;
    if (seen !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", what, ex, seen);
    end
  endtask
  task automatic put(input logic [7:0] tx, input logic ch, input logic r, input logic [7:0] ex,
                     input logic t);
    expQ.push_back({r, ex, {8{r}}, ch ? tx >> 1 : tx, t});
    u_host.xfer(tx, 8, hold);
  endtask
  task automatic acc(input logic [7:0] cmd, input logic [7:0] dat, input logic [7:0] ex);
    logic rdOn;
    rdOn = cmd[7] & (sel | !chainOn);
    if (chainOn) begin
      put({7'($urandom), sel}, 1'b1, 1'b0, 8'h00, 1'b0);
    end
    put(cmd, 1'b0, 1'b0, 8'h00, rdOn & !hold);
    put(dat, 1'b0, rdOn, ex, rdOn & rel & !hold);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    acc({1'b0, a}, v, 8'h00);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] ex);
    acc({1'b1, a}, 8'($urandom), ex);
  endtask
  always @(u_host.done) begin
    logic [25:0] e;
    e = expQ.pop_front();
    check("sdoEn", u_host.en, e[16:9]);
    check("tail", {7'h0, u_host.tail}, {7'h0, e[0]});
    check("pass", u_host.pass, e[8:1]);
    if (e[25]) check("data", u_host.rx, e[24:17]);
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(44396));
    rst = 1'b1;
    irqSrc = '0;
    {rel, hold, chainOn, sel} = 4'b0001;
    pend = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_MODE, MODE_RST);
    rd(7'h7f, 8'h00);
    wr(7'h7f, 8'hff);
    check("irqN", {7'h0, irqN}, 8'h01);
    $display("Reset test done");
    for (int k = 0; k < 3; k++) begin
      hold = (k == 1);
      ena = {5'h0, 19'($urandom)};
      for (int i = 0; i < 3; i++) wr(ADDR_EN1 + 7'(i), ena[8*i +: 8]);
      for (int i = 0; i < 3; i++) rd(ADDR_EN1 + 7'(i), ena[8*i +: 8]);
      @(posedge clk);
      irqSrc <= 19'($urandom);
      @(posedge clk);
      pend = pend | ({5'h0, irqSrc} & ena);
      irqSrc <= '0;
      repeat (2) @(posedge clk);
      check("irqN", {7'h0, irqN}, {7'h0, ~|pend});
      for (int i = 0; i < 3; i++) rd(ADDR_STAT1 + 7'(i), pend[8*i +: 8]);
      clr = (k == 2) ? 24'hffffff : 24'($urandom);
      for (int i = 0; i < 3; i++) wr(ADDR_STAT1 + 7'(i), clr[8*i +: 8]);
      pend = pend & ~clr;
      for (int i = 0; i < 3; i++) rd(ADDR_STAT1 + 7'(i), pend[8*i +: 8]);
      check("irqN", {7'h0, irqN}, {7'h0, ~|pend});
    end
    hold = 1'b0;
    $display("Interrupt test done");
    rel = 1'b1;
    wr(ADDR_MODE, 8'h7f);
    rd(ADDR_MODE, 8'h7f & MODE_WR_MASK);
    u_host.xfer(8'hff, 3, 1'b0);
    rd(ADDR_EN1, ena[7:0]);
    wr(ADDR_MODE, 8'h80);
    {rel, chainOn} = 2'b01;
    d = 8'($urandom);
    wr(ADDR_EN1, d);
    rd(ADDR_EN1, d);
    sel = 1'b0;
    wr(ADDR_EN1, ~d);
    rd(ADDR_EN1, 8'h00);
    sel = 1'b1;
    rd(ADDR_EN1, d);
    wr(ADDR_MODE, 8'h00);
    chainOn = 1'b0;
    rd(ADDR_MODE, 8'h00);
    $display("Mode and chain test done");
    @(posedge clk);
    finish_test();
  end
endmodule
